// ===== hdl/pixel_out_pkg.sv
// Purpose: shared constants and types of the dual-port pixel output formatter
// Assumes: one 50 MHz clock; pixel clock and samples arrive as pins
// Notes: register reset values are plain defaults
package pixel_out_pkg;

    // register addresses on the programming port
    localparam logic [7:0] PHASE_REG_ADDR = 8'h04;
    localparam logic [7:0] FORMAT_REG_ADDR = 8'h15;

    // reset values
    localparam logic [7:0] PHASE_REG_RESET = 8'h00;
    localparam logic [7:0] FORMAT_REG_RESET = 8'h00;

    // field positions
    localparam int PHASE_LSB = 3;
    localparam int PHASE_W = 5;
    localparam int CHAN_MODE_BIT = 7;
    localparam int OUT_MODE_BIT = 6;
    localparam int INVERT_BIT = 5;

    // widths and depths
    localparam int SAMPLE_W = 8;
    localparam int DELAY_DEPTH = 32;
    localparam int FIFO_DEPTH = 4;
    localparam int PERIOD_W = 8;
    localparam int SYNC_WIDTH_W = 8;

    typedef struct packed {
        logic [SAMPLE_W-1:0] red;
        logic [SAMPLE_W-1:0] green;
        logic [SAMPLE_W-1:0] blue;
    } rgb_s;

    typedef struct packed {
        logic hsync;
        rgb_s rgb;
    } pixel_s;

    localparam int PIXEL_W = $bits(pixel_s);

    typedef enum logic [1:0] {
        FMT_SINGLE = 2'b00,
        FMT_PARALLEL = 2'b01,
        FMT_INTERLEAVED = 2'b10
    } fmt_e;

endpackage

// ===== hdl/phase_delay.sv
// Purpose: delays a pixel stream by a programmable number of clock cycles
// Assumes: tap changes are rare; a change may drop or repeat every pixel held between the old and new taps
// Notes: sync and data travel in one word; valid shifts beside it in its own register of equal depth
`timescale 1ns/1ps
`default_nettype none
module phase_delay #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // stream in
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    // delay select
    input wire logic [$clog2(DEPTH)-1:0] tap,
    // stream out
    output logic out_valid,
    output logic [WIDTH-1:0] out_data
);

    logic [DEPTH-1:0] valid_q;
    logic [WIDTH-1:0] data_q [DEPTH];

    always_ff @(posedge clk) begin
        if (reset) begin
            valid_q <= '0;
        end else begin
            valid_q <= {valid_q[DEPTH-2:0], in_valid};
        end
    end

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++) begin : g_stage
            if (i == 0) begin : g_head
                always_ff @(posedge clk) begin
                    data_q[i] <= in_data;
                end
            end else begin : g_tail
                always_ff @(posedge clk) begin
                    data_q[i] <= data_q[i-1];
                end
            end
        end
    endgenerate

    assign out_valid = valid_q[tap];
    assign out_data = data_q[tap];

endmodule
`default_nettype wire

// ===== hdl/pixel_fifo.sv
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: single clock
// Notes: full and empty come from a count, so no slot is wasted
`timescale 1ns/1ps
`default_nettype none
module pixel_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign in_ready = (count_q != (AW+1)'(DEPTH));
    assign out_valid = (count_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule
`default_nettype wire

// ===== hdl/pixel_output_formatter.sv
// Purpose: steers sampled pixels onto two output buses per colour,
//   drives the output strobe clock pair and the rebuilt line sync
// Assumes: pixel clock pin is much slower than clk (at least 4 cycles)
// Notes: registers are written through a plain write strobe port
`timescale 1ns/1ps
`default_nettype none
module pixel_output_formatter
    import pixel_out_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register programming port
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_write,
    output logic [7:0] cfg_rdata,
    // line sync output shape
    input wire logic sync_out_active_high,
    input wire logic [SYNC_WIDTH_W-1:0] sync_out_width,
    // pixel inputs (pins)
    input wire logic pixel_clock_pin,
    input wire logic line_sync_pin,
    input wire logic [SAMPLE_W-1:0] red_sample_pin,
    input wire logic [SAMPLE_W-1:0] green_sample_pin,
    input wire logic [SAMPLE_W-1:0] blue_sample_pin,
    // buffer status
    output logic capture_ready,
    // first output bus
    output logic [SAMPLE_W-1:0] red_first_bus_pixels,
    output logic [SAMPLE_W-1:0] green_first_bus_pixels,
    output logic [SAMPLE_W-1:0] blue_first_bus_pixels,
    // second output bus
    output logic [SAMPLE_W-1:0] red_second_bus_pixels,
    output logic [SAMPLE_W-1:0] green_second_bus_pixels,
    output logic [SAMPLE_W-1:0] blue_second_bus_pixels,
    output logic second_bus_oe_n,
    // strobe pair and line sync
    output logic output_strobe_clock,
    output logic output_strobe_clock_n,
    output logic line_sync_output
);

    // registers
    logic [7:0] phase_reg_q;
    logic [7:0] format_reg_q;
    logic [7:0] rdata_q;

    // pin synchronisers
    logic pclk_s1_q;
    logic pclk_s2_q;
    logic pclk_last_q;
    logic hs_s1_q;
    logic hs_s2_q;
    rgb_s rgb_s1_q;
    rgb_s rgb_s2_q;

    // capture side
    logic pixel_edge;
    pixel_s captured;
    logic [PERIOD_W-1:0] period_cnt_q;
    logic [PERIOD_W-1:0] half_period_q;

    // delayed stream and buffer
    logic dly_valid;
    logic [PIXEL_W-1:0] dly_data;
    logic buf_valid;
    logic buf_ready;
    logic [PIXEL_W-1:0] buf_data;
    pixel_s px;
    logic fire;

    // formatter state
    fmt_e mode;
    logic invert;
    logic lane_q;
    logic lane_now;
    logic hs_last_q;
    logic hs_rise;
    logic gap_q;
    rgb_s first_q;
    rgb_s second_q;
    rgb_s held_q;
    logic second_en_q;
    logic strobe_q;
    logic [PERIOD_W-1:0] strobe_cnt_q;
    logic [SYNC_WIDTH_W-1:0] sync_cnt_q;
    logic sync_active_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            phase_reg_q <= PHASE_REG_RESET;
            format_reg_q <= FORMAT_REG_RESET;
        end else if (cfg_write) begin
            if (cfg_addr == PHASE_REG_ADDR) begin
                phase_reg_q <= cfg_wdata;
            end
            if (cfg_addr == FORMAT_REG_ADDR) begin
                format_reg_q <= cfg_wdata;
            end
        end
    end

    // unmapped addresses read as zero
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (cfg_addr == PHASE_REG_ADDR) begin
            rdata_q <= phase_reg_q;
        end else if (cfg_addr == FORMAT_REG_ADDR) begin
            rdata_q <= format_reg_q;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign cfg_rdata = rdata_q;
    assign invert = format_reg_q[INVERT_BIT];

    always_comb begin
        if (!format_reg_q[CHAN_MODE_BIT]) begin
            mode = FMT_SINGLE;
        end else if (format_reg_q[OUT_MODE_BIT]) begin
            mode = FMT_PARALLEL;
        end else begin
            mode = FMT_INTERLEAVED;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pclk_s1_q <= 1'b0;
            pclk_s2_q <= 1'b0;
            pclk_last_q <= 1'b0;
            hs_s1_q <= 1'b0;
            hs_s2_q <= 1'b0;
        end else begin
            pclk_s1_q <= pixel_clock_pin;
            pclk_s2_q <= pclk_s1_q;
            pclk_last_q <= pclk_s2_q;
            hs_s1_q <= line_sync_pin;
            hs_s2_q <= hs_s1_q;
        end
    end

    always_ff @(posedge clk) begin
        rgb_s1_q <= '{red: red_sample_pin, green: green_sample_pin, blue: blue_sample_pin};
        rgb_s2_q <= rgb_s1_q;
    end

    assign pixel_edge = pclk_s2_q && !pclk_last_q;
    assign captured = '{hsync: hs_s2_q, rgb: rgb_s2_q};

    // in single mode the strobe high time follows the measured pixel period
    always_ff @(posedge clk) begin
        if (reset) begin
            period_cnt_q <= '1;
            half_period_q <= PERIOD_W'(1);
        end else if (pixel_edge) begin
            period_cnt_q <= PERIOD_W'(1);
            // a saturated count spans an idle gap, not a pixel period
            if (period_cnt_q != '1) begin
                half_period_q <= (period_cnt_q > PERIOD_W'(3)) ? (period_cnt_q >> 1) : PERIOD_W'(1);
            end
        end else if (period_cnt_q != '1) begin
            period_cnt_q <= period_cnt_q + 1'b1;
        end
    end

    // phase field delays the sample strobe
    // sync rides with data through one delay
    phase_delay #(
        .WIDTH(PIXEL_W),
        .DEPTH(DELAY_DEPTH)
    ) u_phase_delay (
        .clk(clk),
        .reset(reset),
        .in_valid(pixel_edge),
        .in_data(captured),
        .tap(phase_reg_q[PHASE_LSB +: PHASE_W]),
        .out_valid(dly_valid),
        .out_data(dly_data)
    );

    // pixels drop only if the formatter stalls for four pixels
    pixel_fifo #(
        .WIDTH(PIXEL_W),
        .DEPTH(FIFO_DEPTH)
    ) u_pixel_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(dly_valid),
        .in_ready(capture_ready),
        .in_data(dly_data),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    assign px = pixel_s'(buf_data);
    // one idle cycle between pops keeps strobe edges apart
    assign buf_ready = !gap_q;
    assign fire = buf_valid && buf_ready;
    assign hs_rise = px.hsync && !hs_last_q;

    // lane restarts at every line sync
    assign lane_now = hs_rise ? invert : lane_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            gap_q <= 1'b0;
            lane_q <= 1'b0;
            hs_last_q <= 1'b0;
        end else begin
            gap_q <= fire;
            if (fire) begin
                lane_q <= !lane_now;
                hs_last_q <= px.hsync;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            first_q <= '0;
            second_q <= '0;
            held_q <= '0;
        end else if (fire) begin
            unique case (mode)
                // single mode uses first bus only
                FMT_SINGLE: begin
                    first_q <= px.rgb;
                end
                FMT_PARALLEL: begin
                    if (lane_now == invert) begin
                        held_q <= px.rgb;
                    end else if (lane_now) begin
                        second_q <= px.rgb;
                        first_q <= held_q;
                    end else begin
                        first_q <= px.rgb;
                        second_q <= held_q;
                    end
                end
                FMT_INTERLEAVED: begin
                    if (lane_now) begin
                        second_q <= px.rgb;
                    end else begin
                        first_q <= px.rgb;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            second_en_q <= 1'b0;
        end else begin
            second_en_q <= (mode != FMT_SINGLE);
        end
    end

    // strobe follows the routed pixel timing
    always_ff @(posedge clk) begin
        if (reset) begin
            strobe_q <= 1'b0;
            strobe_cnt_q <= '0;
        end else if (fire) begin
            if (mode == FMT_SINGLE) begin
                strobe_q <= 1'b1;
                strobe_cnt_q <= half_period_q;
            end else begin
                strobe_q <= !strobe_q;
                strobe_cnt_q <= '0;
            end
        end else if (strobe_cnt_q != '0) begin
            strobe_cnt_q <= strobe_cnt_q - 1'b1;
            if (strobe_cnt_q == PERIOD_W'(1)) begin
                strobe_q <= 1'b0;
            end
        end
    end

    // sync rebuilt at each popped pixel
    always_ff @(posedge clk) begin
        if (reset) begin
            sync_cnt_q <= '0;
            sync_active_q <= 1'b0;
        end else if (fire) begin
            if (hs_rise && sync_out_width != '0) begin
                sync_cnt_q <= sync_out_width - 1'b1;
                sync_active_q <= 1'b1;
            end else if (sync_cnt_q != '0) begin
                sync_cnt_q <= sync_cnt_q - 1'b1;
            end else begin
                sync_active_q <= 1'b0;
            end
        end
    end

    assign red_first_bus_pixels = first_q.red;
    assign green_first_bus_pixels = first_q.green;
    assign blue_first_bus_pixels = first_q.blue;
    assign red_second_bus_pixels = second_q.red;
    assign green_second_bus_pixels = second_q.green;
    assign blue_second_bus_pixels = second_q.blue;

    // second bus floats in single mode
    assign second_bus_oe_n = !second_en_q;

    assign output_strobe_clock = strobe_q;
    assign output_strobe_clock_n = !strobe_q;

    assign line_sync_output = sync_out_active_high ? sync_active_q : !sync_active_q;

endmodule
`default_nettype wire

// ===== tb/pixel_output_formatter_sva.sv
// Purpose: port-level checks of the pixel output formatter
// Assumes: registers change only through cfg_write
// Notes: mode checks wait until a format write has settled
`timescale 1ns/1ps
`default_nettype none
module pixel_output_formatter_chk
    import pixel_out_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // register port
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_write,
    input wire logic [7:0] cfg_rdata,
    input wire logic sync_out_active_high,
    // output buses
    input wire logic [SAMPLE_W-1:0] red_first_bus_pixels,
    input wire logic [SAMPLE_W-1:0] green_first_bus_pixels,
    input wire logic [SAMPLE_W-1:0] blue_first_bus_pixels,
    input wire logic [SAMPLE_W-1:0] red_second_bus_pixels,
    input wire logic [SAMPLE_W-1:0] green_second_bus_pixels,
    input wire logic [SAMPLE_W-1:0] blue_second_bus_pixels,
    input wire logic second_bus_oe_n,
    // strobe pair and sync
    input wire logic output_strobe_clock,
    input wire logic output_strobe_clock_n,
    input wire logic line_sync_output
);
    logic [7:0] fmt_q;
    logic [7:0] ph_q;
    logic [1:0] since_q;
    logic [23:0] first_w;
    logic [23:0] second_w;
    assign first_w = {red_first_bus_pixels, green_first_bus_pixels, blue_first_bus_pixels};
    assign second_w = {red_second_bus_pixels, green_second_bus_pixels, blue_second_bus_pixels};
    always_ff @(posedge clk) begin
        if (reset) begin
            fmt_q <= FORMAT_REG_RESET;
            ph_q <= PHASE_REG_RESET;
        end else if (cfg_write && cfg_addr == FORMAT_REG_ADDR) begin
            fmt_q <= cfg_wdata;
        end else if (cfg_write && cfg_addr == PHASE_REG_ADDR) begin
            ph_q <= cfg_wdata;
        end
    end
    // outputs may lag a mode change by a cycle or two
    always_ff @(posedge clk) begin
        if (reset) begin
            since_q <= 2'h3;
        end else if (cfg_write && cfg_addr == FORMAT_REG_ADDR) begin
            since_q <= 2'h0;
        end else if (since_q != 2'h3) begin
            since_q <= since_q + 2'h1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_settled;
        since_q == 2'h3;
    endsequence
    sequence s_single;
        since_q == 2'h3 && !fmt_q[CHAN_MODE_BIT];
    endsequence
    sequence s_dual;
        since_q == 2'h3 && fmt_q[CHAN_MODE_BIT];
    endsequence
    property p_strobe_pair;
        output_strobe_clock_n == !output_strobe_clock;
    endproperty
    a_strobe_pair: assert property (p_strobe_pair) else $error("strobe pair not complementary");
    property p_rd_fmt;
        !cfg_write && cfg_addr == FORMAT_REG_ADDR |=> cfg_rdata == fmt_q;
    endproperty
    a_rd_fmt: assert property (p_rd_fmt) else $error("format register read wrong");
    property p_rd_phase;
        !cfg_write && cfg_addr == PHASE_REG_ADDR |=> cfg_rdata == ph_q;
    endproperty
    a_rd_phase: assert property (p_rd_phase) else $error("phase register read wrong");
    property p_rd_unmapped;
        cfg_addr != FORMAT_REG_ADDR && cfg_addr != PHASE_REG_ADDR |=> cfg_rdata == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_oe_mode;
        s_settled |-> second_bus_oe_n == !fmt_q[CHAN_MODE_BIT];
    endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("second bus enable wrong for mode");
    property p_single_rate;
        s_single ##0 $changed(first_w) |-> $rose(output_strobe_clock);
    endproperty
    a_single_rate: assert property (p_single_rate) else $error("single data without strobe");
    property p_single_pulse;
        s_single ##0 $rose(output_strobe_clock) |-> ##[1:8] !output_strobe_clock;
    endproperty
    a_single_pulse: assert property (p_single_pulse) else $error("single strobe stuck high");
    property p_dual_rate;
        s_dual ##0 ($changed(first_w) || $changed(second_w)) |-> $changed(output_strobe_clock);
    endproperty
    a_dual_rate: assert property (p_dual_rate) else $error("dual data without strobe edge");
    property p_parallel;
        s_dual ##0 fmt_q[OUT_MODE_BIT] ##0 $changed(first_w) |-> $changed(second_w);
    endproperty
    a_parallel: assert property (p_parallel) else $error("parallel buses not updated together");
    property p_interleave;
        s_dual ##0 !fmt_q[OUT_MODE_BIT] ##0 $changed(first_w) |-> $stable(second_w);
    endproperty
    a_interleave: assert property (p_interleave) else $error("interleaved updated both buses");
    property p_sync_idle;
        $fell(reset) |-> line_sync_output != sync_out_active_high;
    endproperty
    a_sync_idle: assert property (p_sync_idle) else $error("line sync active after reset");
    property p_sync_align;
        $changed(line_sync_output) && $stable(sync_out_active_high) |-> $changed(output_strobe_clock);
    endproperty
    a_sync_align: assert property (p_sync_align) else $error("line sync moved off strobe");
endmodule
bind pixel_output_formatter pixel_output_formatter_chk i_chk (.clk(clk), .reset(reset), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_write(cfg_write), .cfg_rdata(cfg_rdata),
    .sync_out_active_high(sync_out_active_high), .red_first_bus_pixels(red_first_bus_pixels),
    .green_first_bus_pixels(green_first_bus_pixels), .blue_first_bus_pixels(blue_first_bus_pixels),
    .red_second_bus_pixels(red_second_bus_pixels), .green_second_bus_pixels(green_second_bus_pixels),
    .blue_second_bus_pixels(blue_second_bus_pixels), .second_bus_oe_n(second_bus_oe_n),
    .output_strobe_clock(output_strobe_clock), .output_strobe_clock_n(output_strobe_clock_n),
    .line_sync_output(line_sync_output));
`default_nettype wire

// ===== tb/pixel_capture_model.sv
// Purpose: downstream logic latching the buses on strobe edges
// Assumes: strobe pair sampled by the bench clock
// Notes: single mode has a return-to-low strobe, so only its rise counts
`timescale 1ns/1ps
`default_nettype none
module pixel_capture_model
    import pixel_out_pkg::*;
(
    // clock and mode
    input wire logic clk,
    input wire logic dual,
    // from the formatter
    input wire logic [23:0] first_bus,
    input wire logic [23:0] second_bus,
    input wire logic strobe,
    input wire logic strobe_n,
    input wire logic line_sync,
    // captured word
    output logic cap_valid,
    output rgb_s cap_first,
    output rgb_s cap_second,
    output logic cap_sync
);
    logic strobe_q;
    logic strobe_n_q;
    always_ff @(posedge clk) begin
        strobe_q <= strobe;
        strobe_n_q <= strobe_n;
        cap_valid <= (strobe && !strobe_q) || (dual && strobe_n && !strobe_n_q);
        cap_first <= first_bus;
        cap_second <= second_bus;
        cap_sync <= line_sync;
    end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: self-checking bench of the pixel output formatter
// Assumes: pixel clock pin at 160 ns, frames of eight pixels
// Notes: driver queues expected captures, monitor checks them in order
`timescale 1ns/1ps
`default_nettype none
module tb
    import pixel_out_pkg::*;
;
    typedef struct packed {
        logic [1:0] mask;
        rgb_s first;
        rgb_s second;
        logic sync_care;
        logic sync_lvl;
        logic head;
    } note_s;
    logic clk, reset, cfg_write, sync_pol, pix_clk, hs_pin, ready, oe_n, stb, stb_n, hs_out, dual, cap_valid, cap_sync;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, sync_w;
    rgb_s pin, cap_first, cap_second;
    wire rgb_s b1, b2;
    note_s notes[$];
    int failures, n_compared;
    time t_cap;
    logic [7:0] fmts[4] = '{8'hC0, 8'h80, 8'hA0, 8'hE0};
    pixel_output_formatter i_dut (.clk(clk), .reset(reset), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_write(cfg_write), .cfg_rdata(cfg_rdata), .sync_out_active_high(sync_pol), .sync_out_width(sync_w),
        .pixel_clock_pin(pix_clk), .line_sync_pin(hs_pin), .red_sample_pin(pin.red),
        .green_sample_pin(pin.green), .blue_sample_pin(pin.blue), .capture_ready(ready),
        .red_first_bus_pixels(b1.red), .green_first_bus_pixels(b1.green), .blue_first_bus_pixels(b1.blue),
        .red_second_bus_pixels(b2.red), .green_second_bus_pixels(b2.green), .blue_second_bus_pixels(b2.blue),
        .second_bus_oe_n(oe_n), .output_strobe_clock(stb), .output_strobe_clock_n(stb_n),
        .line_sync_output(hs_out));
    pixel_capture_model i_cap (.clk(clk), .dual(dual), .first_bus(b1), .second_bus(b2), .strobe(stb),
        .strobe_n(stb_n), .line_sync(hs_out), .cap_valid(cap_valid), .cap_first(cap_first),
        .cap_second(cap_second), .cap_sync(cap_sync));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cfg_addr <= a;
        cfg_wdata <= d;
        cfg_write <= 1'b1;
        @(posedge clk);
        cfg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        cfg_addr <= a;
        @(posedge clk);
        #1 check(cfg_rdata, exp);
    endtask
    // one 160 ns pixel clock period, driven on clk edges
    task automatic pixel(input rgb_s p, input logic hs);
        pin <= p;
        hs_pin <= hs;
        repeat (4) @(posedge clk);
        pix_clk <= 1'b1;
        repeat (4) @(posedge clk);
        pix_clk <= 1'b0;
    endtask
    task automatic frame(input logic [7:0] fmt, input logic [7:0] ph, output int d);
        rgb_s p[8];
        note_s n;
        logic a;
        time t_edge;
        wr(PHASE_REG_ADDR, ph);
        wr(FORMAT_REG_ADDR, fmt);
        dual <= fmt[CHAN_MODE_BIT];
        sync_w <= 8'($urandom_range(1, 4));
        sync_pol <= 1'($urandom_range(0, 1));
        repeat (4) @(posedge clk);
        t_edge = $time + 80;
        for (int k = 0; k < 8; k++) begin
            p[k] = rgb_s'(24'($urandom));
            a = k[0] ^ fmt[INVERT_BIT];
            n = '0;
            n.head = (k == 0);
            n.sync_care = (k == 0) || (k > sync_w);
            n.sync_lvl = (k == 0) ? sync_pol : !sync_pol;
            n.first = p[k];
            n.second = p[k];
            n.mask = 2'b01;
            if (fmt[CHAN_MODE_BIT] && !fmt[OUT_MODE_BIT])
                n.mask = a ? 2'b10 : 2'b01;
            if (fmt[CHAN_MODE_BIT] && fmt[OUT_MODE_BIT]) begin
                n.mask = k[0] ? 2'b11 : 2'b00;
                if (k[0]) begin
                    n.first = a ? p[k-1] : p[k];
                    n.second = a ? p[k] : p[k-1];
                end
            end
            notes.push_back(n);
            pixel(p[k], k == 0);
        end
        // upstream released: lines no longer hold the last pixel
        pin <= ~p[7];
        for (int i = 0; i < 120 && notes.size() != 0; i++)
            @(posedge clk);
        if (notes.size() != 0) begin
            failures++;
            conclude();
        end
        // delay line must drain before the next phase write
        repeat (40) @(posedge clk);
        d = int'(t_cap - t_edge);
    endtask
    initial begin
        note_s n;
        forever begin
            @(posedge clk);
            if (cap_valid === 1'b1) begin
                if (notes.size() == 0) begin
                    check(1, 0);
                end else begin
                    n = notes.pop_front();
                    if (n.head)
                        t_cap = $time;
                    if (n.mask[0])
                        check(cap_first, n.first);
                    if (n.mask[1])
                        check(cap_second, n.second);
                    if (n.sync_care)
                        check(cap_sync, n.sync_lvl);
                end
            end
        end
    end
    initial begin
        int d0, d31;
        failures = 0;
        n_compared = 0;
        reset = 1'b1;
        cfg_addr = 8'h00;
        cfg_wdata = 8'h00;
        cfg_write = 1'b0;
        sync_pol = 1'b1;
        sync_w = 8'h01;
        pix_clk = 1'b0;
        hs_pin = 1'b0;
        pin = '0;
        dual = 1'b0;
        void'($urandom(36));
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rd(PHASE_REG_ADDR, PHASE_REG_RESET);
        rd(FORMAT_REG_ADDR, FORMAT_REG_RESET);
        wr(8'h33, 8'hFF);
        rd(8'h33, 8'h00);
        wr(FORMAT_REG_ADDR, 8'h5A);
        rd(FORMAT_REG_ADDR, 8'h5A);
        check(ready, 1'b1);
        frame(8'h00, 8'h00, d0);
        frame(8'h00, 8'hF8, d31);
        rd(PHASE_REG_ADDR, 8'hF8);
        check(d31 - d0, 31 * 20);
        foreach (fmts[i])
            frame(fmts[i], 8'($urandom_range(0, 31)) << 3, d0);
        conclude();
    end
endmodule
`default_nettype wire
